// ### mms_params.svh
/*
  constants of the mii port: clock rates, mdc divider, rom hand-over counts,
  fifo depth and the rom address bit positions on the shared pins.
  assumes it is included by its bare name from the mii port and from the bench.
*/
// Overview of operation
// [RQ1] transceiver raises collision asynchronously and holds it while the collision lasts
// [RQ2] transceiver raises carrier sense asynchronously whenever the medium is busy
// [RQ3] management clock toward the transceiver never runs faster than 2.5 MHz
// [RQ4] one shared management data line; each side drives only in its turn
// [RQ5] transceiver supplies continuous receive clock, 25 MHz or 2.5 MHz; the bench transceiver model runs its link clocks at 6.25 MHz
// [RQ6] receive nibbles are synchronous to receive clock, line 3 is msb
// [RQ7] receive data valid frames the decoded nibbles, start to end delimiter
// [RQ8] at 100 Mb/s receive error is raised synchronously during a valid frame
// [RQ9] transceiver receive outputs stay disabled for the whole rom access
// [RQ10] transceiver supplies continuous transmit clock within 100 ppm
// [RQ11] transmit nibbles are driven on transmit clock, line 3 is msb
// [RQ12] transmit enable is high exactly while transmit data is valid
// [RQ13] during rom access shared receive and transmit pins carry rom address 6..15
// [RQ14] transceiver pins stay undriven unless the outside transceiver is selected; the rom address still drives the shared pins during rom access
// [RQ15] after rom access pins turn back and receive outputs re-enable before sampling
`ifndef MMS_PARAMS_SVH
`define MMS_PARAMS_SVH
`define MMS_CLK_KHZ      10000
`define MMS_MDC_MAX_KHZ  2500
`define MMS_MDC_MIN_HALF ((`MMS_CLK_KHZ + 2 * `MMS_MDC_MAX_KHZ - 1) / (2 * `MMS_MDC_MAX_KHZ))
`define MMS_MDC_HALF     4
`define MMS_PARK_CYC     2
`define MMS_BACK_CYC     2
`define MMS_FIFO_DEPTH   4
`define MMS_NIB_W        4
`define MMS_ROM_AW       16
`define MMS_RXD_MSB      9
`define MMS_RXD_LSB      6
`define MMS_RXER_BIT     10
`define MMS_RXDV_BIT     11
`define MMS_TXD_MSB      15
`define MMS_TXD_LSB      12
`endif

// ### mms_pkg.sv
/*
  types of the mii port: rom hand-over states and transmit states.
  assumes nothing beyond a tool that reads packages before modules.
*/
package mms_pkg;
  // rom sharing of the mii pins
  typedef enum logic [3:0] {
    MMS_ST_MII  = 4'h1,
    MMS_ST_PARK = 4'h2,
    MMS_ST_ROM  = 4'h4,
    MMS_ST_BACK = 4'h8
  } mms_rom_st_t;
  // transmit framing
  typedef enum logic [1:0] {
    MMS_TX_IDLE = 2'h1,
    MMS_TX_SEND = 2'h2
  } mms_tx_st_t;
endpackage

// ### mms_sync3.sv
/*
  three-flop level synchroniser; a bit changes once stages two and three agree.
  assumes a synchronous active-high reset on the destination clock.
*/
`timescale 1ns/10ps
module mms_sync3 #(
  parameter int W = 1
) (
  input  logic         i_clk,
  input  logic         i_rst,
  input  logic [W-1:0] i_async,
  output logic [W-1:0] o_level
);
  logic [W-1:0] meta_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] level_r;

  if (W < 1) begin : g_chk
    $error("mms_sync3: W must be at least 1");
  end

  // meta_r feeds only s2_r; agreement filter looks at stages two and three
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_r  <= '0;
      s2_r    <= '0;
      s3_r    <= '0;
      level_r <= '0;
    end else begin
      meta_r  <= i_async;
      s2_r    <= meta_r;
      s3_r    <= s2_r;
      level_r <= (s2_r & s3_r) | (level_r & (s2_r | s3_r));
    end
  end

  assign o_level = level_r;
endmodule

// ### mms_fifo.sv
/*
  small flip-flop fifo with valid/ready on both sides and a full flag.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module mms_fifo #(
  parameter int W     = 5,
  parameter int DEPTH = 4
) (
  input  logic         i_clk,
  input  logic         i_rst,
  input  logic         i_valid,
  input  logic [W-1:0] i_data,
  output logic         o_ready,
  output logic         o_valid,
  output logic [W-1:0] o_data,
  input  logic         i_ready,
  output logic         o_full
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem_r [DEPTH];
  logic [AW:0]  wr_r;
  logic [AW:0]  rd_r;
  logic         push;
  logic         pop;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("mms_fifo: DEPTH must be a power of two, at least 2");
  end

  // extra pointer bit tells full from empty
  assign o_full  = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
  assign o_valid = (wr_r != rd_r);
  assign o_ready = !o_full;
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;
  assign o_data  = mem_r[rd_r[AW-1:0]];

  // storage
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_r[wr_r[AW-1:0]] <= i_data;
    end
  end

  // pointers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
    end
  end
endmodule

// ### mms_mii_port.sv
/*
  mac-side mii port: management clock and data line, receive capture on the
  receive clock, transmit framing on the transmit clock behind a small fifo,
  and hand-over of the shared pins to the boot rom address bus.
  assumes the rom controller holds i_rom_req for a whole access and waits for
  o_rom_grant; both link clocks come from the transceiver and run while the
  system reset is held.
*/
`timescale 1ns/10ps
`include "mms_params.svh"
module mms_mii_port #(
  parameter int MDC_HALF   = `MMS_MDC_HALF,
  parameter int PARK_CYC   = `MMS_PARK_CYC,
  parameter int BACK_CYC   = `MMS_BACK_CYC,
  parameter int FIFO_DEPTH = `MMS_FIFO_DEPTH
) (
  input  logic                     i_clk,
  input  logic                     i_sys_rst,
  input  logic                     i_outside_transceiver_select,
  input  logic                     i_rom_req,
  input  logic [`MMS_ROM_AW-1:0]   i_rom_addr,
  output logic                     o_rom_grant,
  input  logic                     i_mgmt_valid,
  input  logic                     i_mgmt_drive,
  input  logic                     i_mgmt_bit,
  output logic                     o_mgmt_ready,
  output logic                     o_mgmt_in_bit,
  output logic                     o_mgmt_in_valid,
  input  logic                     i_col_pin,
  input  logic                     i_crs_pin,
  output logic                     o_col,
  output logic                     o_crs,
  output logic                     o_mdc,
  output logic                     o_mdc_oe,
  input  logic                     i_mdio,
  output logic                     o_mdio,
  output logic                     o_mdio_oe,
  output logic                     o_phy_rx_drive_enable,
  output logic                     o_phy_rx_drive_enable_oe,
  input  logic                     i_rx_clk,
  input  logic [`MMS_NIB_W-1:0]    i_rxd,
  input  logic                     i_rx_er,
  input  logic                     i_rx_dv,
  output logic [`MMS_NIB_W-1:0]    o_rxd,
  output logic                     o_rxd_oe,
  output logic                     o_rx_er,
  output logic                     o_rx_er_oe,
  output logic                     o_rx_dv,
  output logic                     o_rx_dv_oe,
  output logic [`MMS_NIB_W-1:0]    o_rx_nibble,
  output logic                     o_rx_nibble_valid,
  output logic                     o_rx_nibble_err,
  output logic                     o_rx_frame_end,
  input  logic                     i_tx_clk,
  input  logic                     i_tx_valid,
  input  logic [`MMS_NIB_W-1:0]    i_tx_nibble,
  input  logic                     i_tx_last,
  output logic                     o_tx_ready,
  output logic                     o_tx_underrun,
  output logic [`MMS_NIB_W-1:0]    o_txd,
  output logic                     o_txd_oe,
  output logic                     o_tx_en,
  output logic                     o_tx_en_oe
);
  localparam int NW = `MMS_NIB_W;

  mms_pkg::mms_rom_st_t st_r;
  mms_pkg::mms_rom_st_t st_nxt;
  mms_pkg::mms_tx_st_t  tx_st_r;
  mms_pkg::mms_tx_st_t  tx_st_nxt;
  logic [3:0]             rom_cnt_r;
  logic [`MMS_ROM_AW-1:0] rom_addr_r;
  logic                   hold_r;
  logic [7:0]             mdc_cnt_r;
  logic                   mdc_r;
  logic                   mdc_fall;
  logic                   mdio_drive_r;
  logic                   mdio_out_r;
  logic                   listen_r;
  logic                   in_bit_r;
  logic                   in_valid_r;
  logic [2:0]             pin_lvl;
  logic                   ext;
  logic                   rom_drive;
  logic [2:0]             rx_hold_pipe;
  logic                   rx_rst;
  logic [NW-1:0]          rx_nib_r;
  logic                   rx_valid_r;
  logic                   rx_err_r;
  logic                   rx_end_r;
  logic [2:0]             tx_hold_pipe;
  logic                   tx_rst;
  logic                   fifo_in_ready;
  logic                   fifo_valid;
  logic [NW:0]            fifo_data;
  logic                   fifo_full;
  logic                   fifo_take;
  logic                   pop;
  logic [NW-1:0]          txd_r;
  logic                   tx_en_r;
  logic                   underrun_r;

  if (MDC_HALF < `MMS_MDC_MIN_HALF || MDC_HALF > 255) begin : g_chk_mdc
    $error("mms_mii_port: MDC_HALF out of range");
  end
  if (PARK_CYC < 1 || PARK_CYC > 15 || BACK_CYC < 1 || BACK_CYC > 15) begin : g_chk_rom
    $error("mms_mii_port: PARK_CYC and BACK_CYC must be 1 to 15");
  end

  assign ext       = i_outside_transceiver_select;
  assign rom_drive = (st_r == mms_pkg::MMS_ST_ROM);

  // asynchronous collision and carrier, plus the management data line
  mms_sync3 #(
    .W (3)
  ) u_pin_sync (
    .i_clk   (i_clk),
    .i_rst   (i_sys_rst),
    .i_async ({i_mdio, i_crs_pin, i_col_pin}), // see [RQ1] see [RQ2]
    .o_level (pin_lvl)
  );
  assign o_col = pin_lvl[0];
  assign o_crs = pin_lvl[1];

  // rom hand-over sequence: park the receive path, lend the pins, hand them back
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      mms_pkg::MMS_ST_MII:  if (i_rom_req) st_nxt = mms_pkg::MMS_ST_PARK;
      mms_pkg::MMS_ST_PARK: if (rom_cnt_r == 4'h0) st_nxt = mms_pkg::MMS_ST_ROM;
      mms_pkg::MMS_ST_ROM:  if (!i_rom_req) st_nxt = mms_pkg::MMS_ST_BACK;
      mms_pkg::MMS_ST_BACK: if (rom_cnt_r == 4'h0) st_nxt = mms_pkg::MMS_ST_MII; // see [RQ15]
      default:              st_nxt = mms_pkg::MMS_ST_MII;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_r <= mms_pkg::MMS_ST_MII;
    end else begin
      st_r <= st_nxt;
    end
  end

  // wait counter for the park and release phases
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rom_cnt_r <= 4'h0;
    end else if (st_r == mms_pkg::MMS_ST_MII || st_r == mms_pkg::MMS_ST_ROM) begin
      rom_cnt_r <= (st_r == mms_pkg::MMS_ST_MII) ? 4'(PARK_CYC - 1) : 4'(BACK_CYC - 1);
    end else if (rom_cnt_r != 4'h0) begin
      rom_cnt_r <= rom_cnt_r - 4'h1;
    end
  end

  // rom address is registered so the pins switch cleanly
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rom_addr_r <= '0;
    end else begin
      rom_addr_r <= i_rom_addr;
    end
  end

  // link logic is held whenever the pins do not belong to the transceiver
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      hold_r <= 1'b1;
    end else begin
      hold_r <= !(ext && st_r == mms_pkg::MMS_ST_MII); // see [RQ15]
    end
  end

  assign o_rom_grant              = rom_drive;
  assign o_phy_rx_drive_enable    = (st_r == mms_pkg::MMS_ST_MII); // see [RQ9]
  assign o_phy_rx_drive_enable_oe = ext;                           // see [RQ14]
  // the rom address needs the pins even with the internal transceiver in use
  assign o_rxd      = rom_addr_r[`MMS_RXD_MSB:`MMS_RXD_LSB];       // see [RQ13]
  assign o_rx_er    = rom_addr_r[`MMS_RXER_BIT];
  assign o_rx_dv    = rom_addr_r[`MMS_RXDV_BIT];
  assign o_rxd_oe   = rom_drive;
  assign o_rx_er_oe = rom_drive;
  assign o_rx_dv_oe = rom_drive;

  // management clock divider, free running
  assign mdc_fall = mdc_r && (mdc_cnt_r == 8'(MDC_HALF - 1));
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mdc_cnt_r <= 8'h00;
      mdc_r     <= 1'b0;
    end else if (mdc_cnt_r == 8'(MDC_HALF - 1)) begin
      mdc_cnt_r <= 8'h00;
      mdc_r     <= !mdc_r; // see [RQ3]
    end else begin
      mdc_cnt_r <= mdc_cnt_r + 8'h01;
    end
  end

  // one bit per mdc period, launched at the fall; the synchronised line is
  // read at the next fall, since the transceiver changes it after a rise
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !ext) begin
      mdio_drive_r <= 1'b0;
      mdio_out_r   <= 1'b0;
      listen_r     <= 1'b0;
      in_bit_r     <= 1'b0;
      in_valid_r   <= 1'b0;
    end else if (mdc_fall) begin
      mdio_drive_r <= i_mgmt_valid && i_mgmt_drive; // see [RQ4]
      mdio_out_r   <= i_mgmt_valid && i_mgmt_drive && i_mgmt_bit;
      listen_r     <= i_mgmt_valid && !i_mgmt_drive;
      in_bit_r     <= pin_lvl[2];
      in_valid_r   <= listen_r;
    end else begin
      in_valid_r   <= 1'b0;
    end
  end

  assign o_mgmt_ready    = mdc_fall && ext;
  assign o_mgmt_in_bit   = in_bit_r;
  assign o_mgmt_in_valid = in_valid_r;
  assign o_mdc           = mdc_r;
  assign o_mdc_oe        = ext;                  // see [RQ14]
  assign o_mdio          = mdio_out_r;
  assign o_mdio_oe       = ext && mdio_drive_r;  // see [RQ4]

  // receive domain: hold level crosses by three flops and acts as reset
  always_ff @(posedge i_rx_clk) begin
    rx_hold_pipe <= {rx_hold_pipe[1:0], hold_r};
  end
  assign rx_rst = rx_hold_pipe[2];

  // pins are synchronous to the receive clock, so no synchroniser here
  always_ff @(posedge i_rx_clk) begin
    if (rx_rst) begin
      rx_nib_r   <= '0;
      rx_valid_r <= 1'b0;
      rx_err_r   <= 1'b0;
      rx_end_r   <= 1'b0;
    end else begin
      rx_nib_r   <= i_rxd;              // see [RQ6]
      rx_valid_r <= i_rx_dv;            // see [RQ7]
      rx_err_r   <= i_rx_dv && i_rx_er; // see [RQ8]
      rx_end_r   <= rx_valid_r && !i_rx_dv;
    end
  end

  assign o_rx_nibble       = rx_nib_r;
  assign o_rx_nibble_valid = rx_valid_r;
  assign o_rx_nibble_err   = rx_err_r;
  assign o_rx_frame_end    = rx_end_r;

  // transmit domain: same hold crossing
  always_ff @(posedge i_tx_clk) begin
    tx_hold_pipe <= {tx_hold_pipe[1:0], hold_r};
  end
  assign tx_rst = tx_hold_pipe[2];

  mms_fifo #(
    .W     (NW + 1),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .i_clk   (i_tx_clk),
    .i_rst   (tx_rst),
    .i_valid (i_tx_valid && !tx_rst),
    .i_data  ({i_tx_last, i_tx_nibble}),
    .o_ready (fifo_in_ready),
    .o_valid (fifo_valid),
    .o_data  (fifo_data),
    .i_ready (fifo_take),
    .o_full  (fifo_full)
  );
  assign o_tx_ready = fifo_in_ready && !tx_rst;

  // a frame starts only on a full fifo or a last-flagged nibble at the fifo head,
  // so a steady source never underruns; a gap mid-frame still ends the frame
  assign fifo_take = (tx_st_r == mms_pkg::MMS_TX_SEND) || fifo_full || fifo_data[NW];
  assign pop       = fifo_valid && fifo_take;

  always_comb begin
    tx_st_nxt = tx_st_r;
    unique case (tx_st_r)
      mms_pkg::MMS_TX_IDLE: if (pop && !fifo_data[NW]) tx_st_nxt = mms_pkg::MMS_TX_SEND;
      mms_pkg::MMS_TX_SEND: if (!fifo_valid || fifo_data[NW]) tx_st_nxt = mms_pkg::MMS_TX_IDLE;
      default:              tx_st_nxt = mms_pkg::MMS_TX_IDLE;
    endcase
  end

  always_ff @(posedge i_tx_clk) begin
    if (tx_rst) begin
      tx_st_r    <= mms_pkg::MMS_TX_IDLE;
      underrun_r <= 1'b0;
    end else begin
      tx_st_r    <= tx_st_nxt;
      underrun_r <= (tx_st_r == mms_pkg::MMS_TX_SEND) && !fifo_valid;
    end
  end

  // data and enable leave the same flop stage, idle data is zero
  always_ff @(posedge i_tx_clk) begin
    if (tx_rst) begin
      txd_r   <= '0;
      tx_en_r <= 1'b0;
    end else begin
      txd_r   <= pop ? fifo_data[NW-1:0] : '0; // see [RQ11]
      tx_en_r <= pop;                          // see [RQ12]
    end
  end

  assign o_tx_underrun = underrun_r;
  // only the data lines are shared; select switches while the engine is held
  assign o_txd      = rom_drive ? rom_addr_r[`MMS_TXD_MSB:`MMS_TXD_LSB] : txd_r; // see [RQ13]
  assign o_txd_oe   = rom_drive || ext;
  assign o_tx_en    = tx_en_r;
  assign o_tx_en_oe = ext;

  sequence s_park;
    (!o_phy_rx_drive_enable && !o_rom_grant)[*2] ##1 o_rom_grant;
  endsequence
  sequence s_release;
    !o_phy_rx_drive_enable[*2] ##1 o_phy_rx_drive_enable;
  endsequence

  property p_park;
    @(posedge i_clk) disable iff (i_sys_rst)
      ($rose(i_rom_req) && st_r == mms_pkg::MMS_ST_MII) |=> s_park;
  endproperty
  a_park: assert property (p_park) else $error("rom grant before receive park"); // see [RQ9]

  property p_rom_pins;
    @(posedge i_clk) disable iff (i_sys_rst)
      (o_rom_grant && $past(o_rom_grant)) |->
        (o_rxd_oe && o_txd_oe && o_rxd == $past(i_rom_addr[`MMS_RXD_MSB:`MMS_RXD_LSB])
         && o_txd == $past(i_rom_addr[`MMS_TXD_MSB:`MMS_TXD_LSB]));
  endproperty
  a_rom_pins: assert property (p_rom_pins) else $error("rom address not on pins"); // see [RQ13]

  property p_release;
    @(posedge i_clk) disable iff (i_sys_rst)
      ($fell(o_rom_grant) && ext) |-> s_release ##1 !hold_r;
  endproperty
  a_release: assert property (p_release) else $error("pins not handed back"); // see [RQ15]

  property p_hiz;
    @(posedge i_clk) disable iff (i_sys_rst)
      !ext |-> !(o_mdc_oe || o_mdio_oe || o_phy_rx_drive_enable_oe || o_tx_en_oe
                 || (o_txd_oe && !o_rom_grant));
  endproperty
  a_hiz: assert property (p_hiz) else $error("pin driven without outside transceiver"); // see [RQ14]

  // checked at the default half period of four cycles
  property p_mdc;
    @(posedge i_clk) disable iff (i_sys_rst)
      $rose(o_mdc) |-> o_mdc[*4] ##1 !o_mdc[*4];
  endproperty
  a_mdc: assert property (p_mdc) else $error("mdc faster than allowed"); // see [RQ3]

  property p_mdio_turn;
    @(posedge i_clk) disable iff (i_sys_rst)
      $changed(mdio_drive_r) |-> ($fell(o_mdc) || !ext || !$past(ext));
  endproperty
  a_mdio_turn: assert property (p_mdio_turn) else $error("mdio turn off mdc fall"); // see [RQ4]

  property p_rx_cap;
    @(posedge i_rx_clk) disable iff (rx_rst)
      i_rx_dv |=> (o_rx_nibble_valid && o_rx_nibble == $past(i_rxd)
                   && o_rx_nibble_err == $past(i_rx_er));
  endproperty
  a_rx_cap: assert property (p_rx_cap) else $error("receive nibble lost"); // see [RQ6]

  property p_tx_frame;
    @(posedge i_tx_clk) disable iff (tx_rst)
      pop |=> (o_tx_en && txd_r == $past(fifo_data[NW-1:0]));
  endproperty
  a_tx_frame: assert property (p_tx_frame) else $error("transmit nibble not framed"); // see [RQ12]

  property p_tx_idle;
    @(posedge i_tx_clk) disable iff (tx_rst)
      (!o_tx_en ##1 o_tx_en) |-> $past(pop);
  endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("transmit enable without data"); // see [RQ11]
endmodule

// ### mms_phy_model.sv
/*
  behavioural external transceiver: free-running link clocks, receive frames,
  async collision and carrier, management line with pull-down, tx capture.
  assumes the bench calls rx_frame and sets col, crs and p_en/p_val itself.
*/
`timescale 1ns/10ps
module mms_phy_model (
  output logic            o_rx_clk,
  output logic            o_tx_clk,
  output logic [3:0]      o_rxd,
  output logic            o_rx_er,
  output logic            o_rx_dv,
  output logic            o_col,
  output logic            o_crs,
  output wire logic       o_mdio_line,
  input  wire logic       i_rx_out_en,
  input  wire logic [3:0] i_txd,
  input  wire logic       i_tx_en,
  input  wire logic       i_mdio,
  input  wire logic       i_mdio_oe
);
  logic [3:0] rxd_r = 4'h0;
  logic       er_r  = 1'b0;
  logic       dv_r  = 1'b0;
  logic       p_en  = 1'b0;
  logic       p_val = 1'b0;
  logic [3:0] q[$];
  // collision and carrier are set by the bench without any clock
  initial begin
    o_rx_clk = 1'b1;
    o_tx_clk = 1'b0;
    o_col = 1'b0;
    o_crs = 1'b0;
  end
  // continuous link clocks, half a period apart from each other
  always #80 o_rx_clk = ~o_rx_clk;
  always #80 o_tx_clk = ~o_tx_clk;
  // disabled outputs show the inverse, so anything sampled while they are disabled shows up as wrong data
  assign o_rxd   = i_rx_out_en ? rxd_r : ~rxd_r;
  assign o_rx_er = i_rx_out_en ? er_r : ~er_r;
  assign o_rx_dv = i_rx_out_en ? dv_r : ~dv_r;
  // we drive only while the mac has let go; the pull-down wins otherwise
  assign o_mdio_line = i_mdio_oe ? i_mdio : (p_en ? p_val : 1'b0);
  // record every nibble framed by transmit enable
  always @(posedge o_tx_clk) if (i_tx_en === 1'b1) q.push_back(i_txd);
  // one frame of len nibbles, an error flagged on nibble err_at
  task rx_frame(input int len, input int err_at);
    for (int i = 0; i < len; i++) begin
      @(posedge o_rx_clk);
      rxd_r <= 4'(i ^ 5);
      dv_r <= 1'b1;
      er_r <= (i == err_at);
    end
    @(posedge o_rx_clk);
    dv_r <= 1'b0;
    er_r <= 1'b0;
  endtask
endmodule

// ### testbench.sv
/*
  self-checking bench of the mii port against the transceiver model.
  assumes the design defaults for mdc divider, rom counts and fifo depth.
*/
`timescale 1ns/10ps
`include "mms_params.svh"
module testbench;
  logic i_clk = 1'b0, i_sys_rst = 1'b1, i_outside_transceiver_select = 1'b0;
  logic i_rom_req = 1'b0, i_mgmt_valid = 1'b0, i_mgmt_drive = 1'b0, i_mgmt_bit = 1'b0;
  logic i_tx_valid = 1'b0, i_tx_last = 1'b0;
  logic [3:0] i_tx_nibble = 4'h0;
  logic [15:0] i_rom_addr = 16'h0000;
  logic i_col_pin, i_crs_pin, i_mdio, i_rx_clk, i_rx_er, i_rx_dv, i_tx_clk;
  logic [3:0] i_rxd, o_rxd, o_rx_nibble, o_txd;
  logic o_rom_grant, o_mgmt_ready, o_mgmt_in_bit, o_mgmt_in_valid, o_col, o_crs;
  logic o_mdc, o_mdc_oe, o_mdio, o_mdio_oe, o_phy_rx_drive_enable, o_phy_rx_drive_enable_oe;
  logic o_rxd_oe, o_rx_er, o_rx_er_oe, o_rx_dv, o_rx_dv_oe, o_rx_nibble_valid;
  logic o_rx_nibble_err, o_rx_frame_end, o_tx_ready, o_tx_underrun, o_txd_oe;
  logic o_tx_en, o_tx_en_oe;
  int error_cnt = 0, n_checks = 0, cyc = 0, k, m;
  // system clock, 100 ns
  always #50 i_clk = ~i_clk;
  mms_mii_port DUT (.*);
  mms_phy_model phy (
    .o_rx_clk    (i_rx_clk),
    .o_tx_clk    (i_tx_clk),
    .o_rxd       (i_rxd),
    .o_rx_er     (i_rx_er),
    .o_rx_dv     (i_rx_dv),
    .o_col       (i_col_pin),
    .o_crs       (i_crs_pin),
    .o_mdio_line (i_mdio),
    .i_rx_out_en (o_phy_rx_drive_enable),
    .i_txd       (o_txd),
    .i_tx_en     (o_tx_en),
    .i_mdio      (o_mdio),
    .i_mdio_oe   (o_mdio_oe)
  );
  task chk(input bit ok, input string msg);
    n_checks++;
    if (!ok) begin
      error_cnt++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // a hang costs a mismatch; the whole run needs about 200 cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop;
    end
  end
  task t_off;
    @(negedge i_clk);
    chk(o_mdc_oe === 1'b0 && o_tx_en_oe === 1'b0 && o_txd_oe === 1'b0 &&
        o_mdio_oe === 1'b0 && o_phy_rx_drive_enable_oe === 1'b0, "pins driven");
    $display("test off done");
  endtask
  task t_colcrs;
    chk(o_mdc_oe === 1'b1 && o_tx_en_oe === 1'b1 && o_phy_rx_drive_enable_oe === 1'b1,
        "pins not driven");
    #7 phy.o_col = 1'b1;
    repeat (5) @(negedge i_clk);
    chk(o_col === 1'b1 && o_crs === 1'b0, "collision");
    phy.o_col = 1'b0;
    phy.o_crs = 1'b1;
    repeat (5) @(negedge i_clk);
    chk(o_col === 1'b0 && o_crs === 1'b1, "carrier");
    phy.o_crs = 1'b0;
    $display("test col crs done");
  endtask
  // offer one bit and hold it offered until an edge takes it
  task mgmt(input logic drv, input logic b);
    @(posedge i_clk);
    i_mgmt_valid <= 1'b1;
    i_mgmt_drive <= drv;
    i_mgmt_bit <= b;
    k = 0;
    do begin @(negedge i_clk); k++; end while (o_mgmt_ready !== 1'b1 && k < 40);
    @(posedge i_clk);
    @(negedge i_clk);
  endtask
  task t_mgmt;
    mgmt(1'b1, 1'b1);
    chk(o_mdio_oe === 1'b1 && o_mdio === 1'b1, "mdio one");
    mgmt(1'b1, 1'b0);
    chk(o_mdio_oe === 1'b1 && o_mdio === 1'b0, "mdio zero");
    mgmt(1'b0, 1'b0);
    chk(o_mdio_oe === 1'b0, "mdio kept");
    phy.p_en = 1'b1;
    phy.p_val = 1'b1;
    k = 0;
    do begin @(negedge i_clk); k++; end while (o_mgmt_in_valid !== 1'b1 && k < 20);
    chk(o_mgmt_in_bit === 1'b1, "listen bit");
    m = 0;
    do begin @(negedge i_clk); m++; end while (o_mdc !== 1'b1 && m < 20);
    m = 0;
    do begin @(negedge i_clk); m++; end while (o_mdc === 1'b1 && m < 20);
    do begin @(negedge i_clk); m++; end while (o_mdc === 1'b0 && m < 40);
    chk(m >= 2 * `MMS_MDC_MIN_HALF, "mdc too fast");
    @(posedge i_clk);
    i_mgmt_valid <= 1'b0;
    phy.p_en = 1'b0;
    $display("test mgmt done");
  endtask
  task push(input logic [3:0] n, input logic l);
    i_tx_valid <= 1'b1;
    i_tx_nibble <= n;
    i_tx_last <= l;
    k = 0;
    do begin @(negedge i_tx_clk); k++; end while (o_tx_ready !== 1'b1 && k < 20);
    @(posedge i_tx_clk);
  endtask
  // a closed frame, then one left open so the engine runs dry and flags it
  task t_tx;
    @(posedge i_tx_clk);
    for (int f = 0; f < 2; f++) begin
      for (int i = 0; i < 4; i++) push(4'(3 * i + 1), f == 0 && i == 3);
      i_tx_valid <= 1'b0;
      m = 0;
      repeat (16) begin
        @(negedge i_tx_clk);
        if (o_tx_underrun === 1'b1) m++;
      end
      chk(phy.q.size() == 4 * f + 4 && m == f, "tx framing");
      @(posedge i_tx_clk);
    end
    foreach (phy.q[i]) chk(phy.q[i] === 4'(3 * (i % 4) + 1), "tx nibble");
    $display("test tx done");
  endtask
  task t_rom;
    @(posedge i_clk);
    i_rom_addr <= 16'hA5C3;
    i_rom_req <= 1'b1;
    k = 0;
    do begin @(negedge i_clk); k++; end while (o_rom_grant !== 1'b1 && k < 10);
    repeat (3) @(negedge i_tx_clk);
    chk(o_phy_rx_drive_enable === 1'b0 && o_rxd_oe === 1'b1 && o_rx_er_oe === 1'b1 &&
        o_rx_dv_oe === 1'b1 && o_txd_oe === 1'b1, "rom pin direction");
    chk(o_rxd === 4'h7 && o_rx_er === 1'b1 && o_rx_dv === 1'b0 && o_txd === 4'hA,
        "rom address");
    @(posedge i_clk);
    i_rom_req <= 1'b0;
    k = 0;
    do begin @(negedge i_clk); k++; end while (o_phy_rx_drive_enable !== 1'b1 && k < 10);
    chk(o_rom_grant === 1'b0 && o_rxd_oe === 1'b0 && k < 10, "pins returned");
    $display("test rom done");
  endtask
  // nibbles must come out in order, error on the fourth, one frame end
  task t_rx;
    k = 0;
    m = 0;
    fork
      phy.rx_frame(6, 3);
      repeat (24) begin
        @(negedge i_rx_clk);
        if (o_rx_nibble_valid === 1'b1) begin
          chk(o_rx_nibble === 4'(k ^ 5) && o_rx_nibble_err === (k == 3), "rx nibble");
          k++;
        end
        if (o_rx_frame_end === 1'b1) m++;
      end
    join
    chk(k == 6 && m == 1, "rx frame");
    $display("test rx done");
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    t_off;
    @(posedge i_clk);
    i_outside_transceiver_select <= 1'b1;
    repeat (8) @(posedge i_rx_clk);
    t_colcrs;
    t_mgmt;
    t_tx;
    t_rom;
    repeat (8) @(posedge i_rx_clk);
    t_rx;
    report_and_stop;
  end
endmodule
